// File: design/sep_pkg.sv
// package: opcodes, status layout, timing constants and carrier types
package sep_pkg;
  localparam logic [7:0] OP_ENABLE_WRITES  = 8'h06;
  localparam logic [7:0] OP_DISABLE_WRITES = 8'h04;
  localparam logic [7:0] OP_STATUS_READ    = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
  localparam logic [7:0] OP_MEM_READ       = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE      = 8'h02;

  localparam int BIT_READY      = 0;
  localparam int BIT_WEL        = 1;
  localparam int BIT_BP_LO      = 2;
  localparam int BIT_BP_HI      = 3;
  localparam int BIT_PAGE_LOCK  = 4;
  localparam int BIT_PAGE_SEL   = 6;
  localparam int BIT_PIN_ENABLE = 7;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'hDC;

  localparam logic [14:0] QUARTER_BASE = 15'h6000;
  localparam logic [14:0] HALF_BASE    = 15'h4000;

  localparam int CLK_FREQ_HZ     = 25000000;
  localparam int WRITE_CYCLE_US  = 5000;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * (CLK_FREQ_HZ / 1000000);
  localparam int BITS_PER_BYTE   = 8;
  localparam int ADDR_BITS       = 16;
  localparam int FIFO_DEPTH      = 16;

  typedef enum logic [1:0] {
    WK_NONE,
    WK_ARRAY,
    WK_STATUS
  } sep_write_kind_t;

  typedef struct packed {
    logic        idPage;
    logic [14:0] addr;
    logic [7:0]  data;
  } sep_wr_word_t;

  typedef struct packed {
    logic pinEnable;
    logic pageSel;
    logic pageLock;
    logic bpHi;
    logic bpLo;
  } sep_nv_bits_t;
endpackage

// File: design/sep_fifo.sv
// fifo with valid/ready on both sides
`timescale 1ns/100ps
module sep_fifo
  import sep_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/sep_command_protect.sv
// spi eeprom command front end with status byte and write protection
`timescale 1ns/100ps
module sep_command_protect
  import sep_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               serClk,
  input  wire logic               selectN,
  input  wire logic               serIn,
  input  wire logic               holdN,
  input  wire logic               protectN,
  output logic                    serOut,
  output logic                    serOutEn,
  output logic                    standby,
  output logic                    wrValid,
  input  wire logic               wrReady,
  output sep_wr_word_t            wrWord,
  output logic                    rdReq,
  output logic                    rdIdPage,
  output logic [14:0]             rdAddr,
  input  wire logic [7:0]         rdData,
  output logic                    busy,
  output logic [7:0]              statusByte
);
  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_IDLE
  } sep_phase_t;

  logic [1:0] sclkSync_ff, selSync_ff, siSync_ff, holdSync_ff, wpSync_ff;
  logic       sclkPrev_ff;
  logic       selPrev_ff;
  logic       sclkRise, sclkFall, selRise, selFall, selLow, holdOk;
  sep_phase_t phase_ff;
  logic [7:0] opcode_ff;
  logic [7:0] shiftIn_ff;
  logic [2:0] bitCnt_ff;
  logic [15:0] addr_ff;
  logic [7:0] outShift_ff;
  logic       outActive_ff;
  logic       serOut_ff;
  logic       wel_ff;
  sep_nv_bits_t nv_ff;
  logic [31:0] wcCnt_ff;
  logic       busy_ff;
  logic       wrPending_ff;
  logic       stPending_ff;
  logic [7:0] stNew_ff;
  logic       opUsed_ff;
  logic       hwProtect, arrProtected, byteDone, fifoInValid, fifoInReady;
  logic [7:0] nxt_byte;
  sep_wr_word_t fifoIn;

  // two-flop synchronisers for all pins
  always_ff @(posedge clk) begin
    if (srst) begin
      sclkSync_ff <= '0;
      selSync_ff  <= 2'h3;
      siSync_ff   <= '0;
      holdSync_ff <= 2'h3;
      wpSync_ff   <= 2'h3;
    end else begin
      sclkSync_ff <= {sclkSync_ff[0], serClk};
      selSync_ff  <= {selSync_ff[0], selectN};
      siSync_ff   <= {siSync_ff[0], serIn};
      holdSync_ff <= {holdSync_ff[0], holdN};
      wpSync_ff   <= {wpSync_ff[0], protectN};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclkPrev_ff <= 1'b0;
      selPrev_ff  <= 1'b1;
    end else begin
      sclkPrev_ff <= sclkSync_ff[1];
      selPrev_ff  <= selSync_ff[1];
    end
  end

  assign selLow   = !selSync_ff[1];
  assign holdOk   = holdSync_ff[1];
  assign sclkRise = sclkSync_ff[1] && !sclkPrev_ff && selLow && holdOk;
  assign sclkFall = !sclkSync_ff[1] && sclkPrev_ff && selLow && holdOk;
  assign selRise  = selSync_ff[1] && !selPrev_ff;
  assign selFall  = !selSync_ff[1] && selPrev_ff;
  assign nxt_byte = {shiftIn_ff[6:0], siSync_ff[1]};
  assign byteDone = sclkRise && (bitCnt_ff == 3'h7);

  // protection decode
  assign hwProtect = nv_ff.pinEnable && !wpSync_ff[1];
  always_comb begin
    unique case ({nv_ff.bpHi, nv_ff.bpLo})
      2'b00:   arrProtected = 1'b0;
      2'b01:   arrProtected = (addr_ff[14:0] >= QUARTER_BASE);
      2'b10:   arrProtected = (addr_ff[14:0] >= HALF_BASE);
      2'b11:   arrProtected = 1'b1;
    endcase
  end

  // shift, opcode and phase tracking
  always_ff @(posedge clk) begin
    if (srst || selFall || !selLow) begin
      phase_ff   <= ST_OPCODE;
      bitCnt_ff  <= '0;
      shiftIn_ff <= '0;
      opcode_ff  <= '0;
      addr_ff    <= '0;
    end else if (sclkRise) begin
      shiftIn_ff <= nxt_byte;
      bitCnt_ff  <= bitCnt_ff + 3'h1;
      unique case (phase_ff)
        ST_OPCODE: begin
          if (bitCnt_ff == 3'h7) begin
            opcode_ff <= nxt_byte;
            if (busy_ff && nxt_byte != OP_STATUS_READ) begin
              phase_ff <= ST_IDLE;
            end else if (nxt_byte == OP_MEM_READ || nxt_byte == OP_MEM_WRITE) begin
              phase_ff <= ST_ADDR;
            end else if (nxt_byte == OP_STATUS_WRITE || nxt_byte == OP_STATUS_READ) begin
              phase_ff <= ST_DATA;
            end else begin
              phase_ff <= ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          addr_ff <= {addr_ff[14:0], siSync_ff[1]};
          if (bitCnt_ff == 3'h7 && opUsed_ff) begin
            phase_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (byteDone && opcode_ff != OP_STATUS_WRITE) begin
            addr_ff <= (nv_ff.pageSel) ? {addr_ff[15:6], addr_ff[5:0] + 6'h01}
                                       : addr_ff + 16'h0001;
          end
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  // counts address bytes: second address byte moves to data phase
  always_ff @(posedge clk) begin
    if (srst || selFall || !selLow) begin
      opUsed_ff <= 1'b0;
    end else if (byteDone && phase_ff == ST_ADDR) begin
      opUsed_ff <= 1'b1;
    end
  end

  // output shifter, falling-edge driven
  always_ff @(posedge clk) begin
    if (srst || !selLow) begin
      outShift_ff  <= '0;
      outActive_ff <= 1'b0;
      serOut_ff    <= 1'b0;
    end else if (sclkFall && (phase_ff == ST_DATA) &&
                 (opcode_ff == OP_STATUS_READ || opcode_ff == OP_MEM_READ)) begin
      if (bitCnt_ff == 3'h0) begin
        serOut_ff   <= (opcode_ff == OP_STATUS_READ) ? statusByte[7] : rdData[7];
        outShift_ff <= (opcode_ff == OP_STATUS_READ) ? {statusByte[6:0], 1'b0}
                                                     : {rdData[6:0], 1'b0};
      end else begin
        serOut_ff   <= outShift_ff[7];
        outShift_ff <= {outShift_ff[6:0], 1'b0};
      end
      outActive_ff <= 1'b1;
    end
  end

  assign serOut   = serOut_ff;
  assign serOutEn = outActive_ff && selLow && holdOk;
  assign standby  = !selLow && !busy_ff;
  assign rdReq    = sclkFall && phase_ff == ST_DATA && opcode_ff == OP_MEM_READ
                    && bitCnt_ff == 3'h0;
  assign rdIdPage = nv_ff.pageSel;
  assign rdAddr   = addr_ff[14:0];

  // array write words go to the fifo; protected bytes are dropped
  assign fifoIn.idPage = nv_ff.pageSel;
  assign fifoIn.addr   = addr_ff[14:0];
  assign fifoIn.data   = nxt_byte;
  assign fifoInValid   = byteDone && phase_ff == ST_DATA && opcode_ff == OP_MEM_WRITE
                         && wel_ff && !arrProtected
                         && !(nv_ff.pageSel && nv_ff.pageLock);

  sep_fifo #(
    .WIDTH ($bits(sep_wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (fifoInValid && fifoInReady),
    .inReady  (fifoInReady),
    .inData   (fifoIn),
    .outValid (wrValid),
    .outReady (wrReady && busy_ff),
    .outData  (wrWord)
  );

  // pending write commits
  always_ff @(posedge clk) begin
    if (srst || selFall) begin
      wrPending_ff <= 1'b0;
      stPending_ff <= 1'b0;
      stNew_ff     <= '0;
    end else begin
      if (fifoInValid) begin
        wrPending_ff <= 1'b1;
      end
      if (byteDone && phase_ff == ST_DATA && opcode_ff == OP_STATUS_WRITE
          && wel_ff && !hwProtect) begin
        stPending_ff <= 1'b1;
        stNew_ff     <= nxt_byte;
      end
      if (selLow && hwProtect) begin
        stPending_ff <= 1'b0;
      end
    end
  end

  // self-timed write cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_ff  <= 1'b0;
      wcCnt_ff <= '0;
    end else if (selRise && (wrPending_ff || stPending_ff)) begin
      busy_ff  <= 1'b1;
      wcCnt_ff <= 32'(WRITE_CYCLES - 1);
    end else if (busy_ff) begin
      if (wcCnt_ff == '0 && !wrValid) begin
        busy_ff <= 1'b0;
      end else if (wcCnt_ff != '0) begin
        wcCnt_ff <= wcCnt_ff - 32'h1;
      end
    end
  end

  // write-enable latch
  always_ff @(posedge clk) begin
    if (srst) begin
      wel_ff <= 1'b0;
    end else if (busy_ff && wcCnt_ff == '0 && !wrValid) begin
      wel_ff <= 1'b0;
    end else if (selRise && phase_ff == ST_IDLE && !busy_ff) begin
      if (opcode_ff == OP_ENABLE_WRITES) begin
        wel_ff <= 1'b1;
      end else if (opcode_ff == OP_DISABLE_WRITES) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // status control bits
  always_ff @(posedge clk) begin
    if (srst) begin
      nv_ff <= '0;
    end else if (selRise && stPending_ff) begin
      nv_ff.pinEnable <= stNew_ff[BIT_PIN_ENABLE];
      nv_ff.bpHi      <= stNew_ff[BIT_BP_HI];
      nv_ff.bpLo      <= stNew_ff[BIT_BP_LO];
      if (!(stNew_ff[BIT_PAGE_SEL] && stNew_ff[BIT_PAGE_LOCK])) begin
        nv_ff.pageSel  <= stNew_ff[BIT_PAGE_SEL];
        nv_ff.pageLock <= nv_ff.pageLock || stNew_ff[BIT_PAGE_LOCK];
      end
    end else if (selRise && phase_ff == ST_DATA &&
                 (opcode_ff == OP_MEM_READ || opcode_ff == OP_MEM_WRITE)) begin
      nv_ff.pageSel <= 1'b0;
    end
  end

  assign busy = busy_ff;
  always_comb begin
    statusByte                 = 8'h00;
    statusByte[BIT_READY]      = busy_ff;
    statusByte[BIT_WEL]        = wel_ff;
    statusByte[BIT_BP_LO]      = nv_ff.bpLo;
    statusByte[BIT_BP_HI]      = nv_ff.bpHi;
    statusByte[BIT_PAGE_LOCK]  = nv_ff.pageLock;
    statusByte[BIT_PAGE_SEL]   = nv_ff.pageSel;
    statusByte[BIT_PIN_ENABLE] = nv_ff.pinEnable;
  end
endmodule

// File: bench/sep_chk.sv
// port assertions for the command front end
`timescale 1ns/100ps
module sep_chk
  import sep_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC
) (
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         serClk,
  input wire logic         selectN,
  input wire logic         holdN,
  input wire logic         serOut,
  input wire logic         serOutEn,
  input wire logic         standby,
  input wire logic         wrValid,
  input wire logic         wrReady,
  input wire sep_wr_word_t wrWord,
  input wire logic         rdReq,
  input wire logic         rdIdPage,
  input wire logic         busy,
  input wire logic [7:0]   statusByte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_sel_idle_quiet: assert property (selectN [*4] |-> !serOutEn)
    else $error("output driven while deselected");
  a_standby_idle: assert property ((selectN && !busy) [*4] |-> standby)
    else $error("standby missing while idle");
  a_out_on_fall: assert property ($changed(serOut) && serOutEn |-> !serClk)
    else $error("serial output moved while clock high");
  a_hold_quiet: assert property (!holdN [*3] |-> !serOutEn)
    else $error("output driven during pause");
  a_ready_busy: assert property ($stable(busy) |-> statusByte[0] == busy)
    else $error("ready flag differs from write cycle");
  a_bit5_zero: assert property (statusByte[5] == 1'b0)
    else $error("status bit 5 set");
  a_page_pair: assert property ($rose(statusByte[6]) |-> !$rose(statusByte[4]))
    else $error("page select and lock set together");
  a_wel_done_clear: assert property ($fell(busy) |-> ##[0:2] !statusByte[1])
    else $error("latch kept after write cycle");
  a_busy_on_rise: assert property ($rose(busy) |-> selectN)
    else $error("write cycle began while selected");
  a_full_protect: assert property (wrValid |-> !(statusByte[3] && statusByte[2]))
    else $error("write queued under full protection");
  a_quarter_range: assert property (wrValid && !wrWord.idPage && statusByte[2]
    |-> wrWord.addr < QUARTER_BASE)
    else $error("write queued into protected quarter");
  a_lock_page: assert property (wrValid && wrWord.idPage |-> !statusByte[4])
    else $error("write queued to locked page");
  a_write_latch: assert property ($rose(wrValid) |-> statusByte[1])
    else $error("write queued without latch");
  c_write_cycle: cover property ($rose(busy));
  c_word_taken: cover property (wrValid && wrReady);
  c_id_read: cover property (rdReq && rdIdPage);
endmodule

bind sep_command_protect sep_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .serClk(serClk), .selectN(selectN), .holdN(holdN),
  .serOut(serOut),
  .serOutEn(serOutEn), .standby(standby), .wrValid(wrValid), .wrReady(wrReady),
  .wrWord(wrWord), .rdReq(rdReq), .rdIdPage(rdIdPage), .busy(busy),
  .statusByte(statusByte));

// File: bench/sep_host.sv
// spi host model driving clock, select and data pins
`timescale 1ns/100ps
module sep_host (
  input  wire logic clk,
  input  wire logic serOut,
  output logic      serClk,
  output logic      selectN,
  output logic      serIn,
  output logic      holdN
);
  int   pauseAt = -1;
  logic cpol    = 1'b0;
  initial begin
    serClk  = 1'b0;
    selectN = 1'b1;
    serIn   = 1'b0;
    holdN   = 1'b1;
  end
  // half clock period of 4 cycles gives 160 ns
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one session of n bytes, msb first; cpol picks mode 0 or mode 3
  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    if (serClk !== cpol) begin
      serClk = cpol;
      gap(4);
    end
    gap(1);
    selectN = 1'b0;
    gap(4);
    for (int i = 8 * n - 1; i >= 0; i--) begin
      serClk = 1'b0;
      if (i == pauseAt) begin
        gap(4);
        holdN = 1'b0;
        serIn = ~tx[i];
        gap(4);
        serClk = 1'b1;
        gap(4);
        serClk = 1'b0;
        gap(4);
        holdN = 1'b1;
      end
      serIn = tx[i];
      gap(4);
      serClk = 1'b1;
      rx = {rx[30:0], serOut};
      gap(4);
    end
    serClk = cpol;
    gap(4);
    selectN = 1'b1;
    serIn = ~serIn;
    gap(4);
  endtask
endmodule

// File: bench/tb_sep_command_protect.sv
// self-checking bench for the command front end
`timescale 1ns/100ps
module tb_sep_command_protect;
  import sep_pkg::*;
  localparam int WCYC = 400;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         holdN;
  logic         protectN = 1'b1;
  logic         wrReady = 1'b0;
  logic [7:0]   rdData;
  logic         serClk, selectN, serIn, serOut, serOutEn, standby;
  logic         wrValid, rdReq, rdIdPage, busy;
  logic [14:0]  rdAddr;
  logic [7:0]   statusByte;
  sep_wr_word_t wrWord;
  logic [31:0]  rx;
  int           error_cnt = 0;
  int           total_checks = 0;

  always #20 clk = ~clk;
  // array model: byte derived from address and page
  assign rdData = rdAddr[7:0] ^ {7'h00, rdIdPage};

  sep_host u_host (.clk(clk), .serOut(serOut), .serClk(serClk), .selectN(selectN),
    .serIn(serIn), .holdN(holdN));
  sep_command_protect #(.WRITE_CYCLES(WCYC)) u_dut (
    .clk(clk), .srst(srst), .serClk(serClk), .selectN(selectN), .serIn(serIn),
    .holdN(holdN), .protectN(protectN), .serOut(serOut), .serOutEn(serOutEn),
    .standby(standby), .wrValid(wrValid), .wrReady(wrReady), .wrWord(wrWord),
    .rdReq(rdReq), .rdIdPage(rdIdPage), .rdAddr(rdAddr), .rdData(rdData),
    .busy(busy), .statusByte(statusByte));

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [31:0] tx, input int n);
    u_host.frame(tx, n, rx);
  endtask
  task automatic stat(input logic [7:0] exp, input string what);
    u_host.frame(32'h0500, 2, rx);
    check(what, rx[7:0], exp);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2000) begin
      error_cnt++;
      results();
    end
  endtask

  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    stat(8'h00, "status after reset");
    check("status port", statusByte, 8'h00);
    cmd(32'hFF, 1);
    cmd(32'h019C, 2);
    stat(8'h00, "unlatched writes");
    cmd(32'h06, 1);
    stat(8'h02, "latch set");
    cmd(32'h04, 1);
    stat(8'h00, "latch cleared");
    cmd(32'h06, 1);
    cmd(32'h01FF, 2);
    check("ready while busy", statusByte[0], 1'b1);
    cmd(32'h06, 1);
    wait_idle();
    stat(8'h8C, "masked status write");
    protectN = 1'b0;
    cmd(32'h06, 1);
    cmd(32'h0100, 2);
    wait_idle();
    stat(8'h8E, "pin protected status");
    protectN = 1'b1;
    cmd(32'h0104, 2);
    wait_idle();
    stat(8'h04, "quarter protect");
    cmd(32'h06, 1);
    cmd(32'h0270005A, 4);
    check("protected write", wrValid, 1'b0);
    wait_idle();
    cmd(32'h06, 1);
    cmd(32'h0212345A, 4);
    check("write word", wrWord, {1'b0, 15'h1234, 8'h5A});
    check("write queued", wrValid, 1'b1);
    wrReady = 1'b1;
    wait_idle();
    stat(8'h04, "latch after write");
    cmd(32'h03001000, 4);
    check("array read", rx[7:0], 8'h10);
    u_host.cpol = 1'b1;
    cmd(32'h03001000, 4);
    check("array read mode 3", rx[7:0], 8'h10);
    u_host.cpol = 1'b0;
    u_host.pauseAt = 4;
    stat(8'h04, "status across pause");
    u_host.pauseAt = -1;
    cmd(32'h06, 1);
    cmd(32'h0140, 2);
    wait_idle();
    stat(8'h40, "page select set");
    cmd(32'h03000500, 4);
    check("page read", rx[7:0], 8'h04);
    stat(8'h00, "page select cleared");
    results();
  end
endmodule
